// >>> hdl/dcoc_bank.sv
/*
  Per-channel output configuration register bank of a smart DAC, with the
  channel update, clear and comparator logic that the registers steer.
  Assumes the serial front end hands over one decoded register access per
  cycle, with the PMBus page when PMBus addressing is in use.
*/
// Function
// - Range codes 0000 to 0011 pick sourcing ranges of 25, 50, 125, 250 uA.
// - Codes 0100 to 0111 sink; 0110 and 0111 sink up to 120 and 240 uA.
// - Range codes 1000 to 1011 pick bipolar ranges; other codes are invalid.
// - Comparator mode 00 compares with no hysteresis and no window.
// - Comparator mode 01 applies hysteresis between the two margins.
// - Comparator mode 10 is a window between the margins and 11 is invalid.
// - The clear level bit clears to zero-scale when 0 and mid-scale when 1.
// - With the deferred bit at 0 the output changes right after a write.
// - Deferred bit 1: the output waits for a strobe fall or trigger load.
// - The broadcast bit makes the channel accept broadcast writes when 1.
// - Under PMBus the range register sits on page ffh at deh or d2h.
// - Under PMBus the mode register sits on page ffh at dfh or d3h.
// - The function register is at page ffh, e0h or d4h; all reset to 0000h.
module dcoc_bank #(
  parameter int NUM_CH = 2,
  parameter int CODE_W = 12
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pmbus_mode_i,
  input wire logic [7:0] pmbus_page_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_hit_o,
  input wire logic code_wr_i,
  input wire logic [NUM_CH-1:0] code_ch_i,
  input wire logic bcast_wr_i,
  input wire logic [CODE_W-1:0] code_i,
  input wire logic load_strobe_pin_i,
  input wire logic trigger_load_i,
  input wire logic clear_i,
  input wire logic [NUM_CH-1:0] comparator_enable_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] fb_code_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] margin_hi_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] margin_lo_i,
  output logic [NUM_CH-1:0][CODE_W-1:0] dac_code_o,
  output dcoc_pkg::dcoc_chan_cfg_t [NUM_CH-1:0] cfg_o,
  output dcoc_pkg::dcoc_chan_stat_t [NUM_CH-1:0] stat_o
);

  if (NUM_CH < 1 || NUM_CH > dcoc_pkg::MAX_CH) begin : g_bad_ch
    $error("NUM_CH must be 1 or 2");
  end
  if (CODE_W < 2 || CODE_W > dcoc_pkg::DATA_W) begin : g_bad_w
    $error("CODE_W must lie between 2 and 16");
  end

  // Decoded access: which channel and which register.
  logic dec_hit;
  logic dec_ch;
  dcoc_pkg::dcoc_reg_sel_t dec_sel;

  // Stored fields; only defined bits have flip-flops.
  logic [NUM_CH-1:0][3:0] range_q;
  logic [NUM_CH-1:0][1:0] mode_q;
  logic [NUM_CH-1:0] clr_sel_q;
  logic [NUM_CH-1:0] defer_q;
  logic [NUM_CH-1:0] bcast_q;
  logic [NUM_CH-1:0][12:0] wave_q;

  // Load strobe history, for the falling edge.
  logic load_pin_q;
  logic load_pulse;

  // Kept apart so that every stat_o entry has a single driver.
  logic [NUM_CH-1:0] chan_pending;
  logic [NUM_CH-1:0] chan_cmp;

  // The two register families share one decoder; PMBus needs the page too.
  always_comb begin
    dec_hit = 1'b1;
    dec_ch = 1'b0;
    dec_sel = dcoc_pkg::DCOC_SEL_NONE;
    if (pmbus_mode_i) begin
      unique case (reg_addr_i)
        dcoc_pkg::PMB_RANGE_LO: begin
          dec_sel = dcoc_pkg::DCOC_SEL_RANGE;
        end
        dcoc_pkg::PMB_MODE_LO: begin
          dec_sel = dcoc_pkg::DCOC_SEL_MODE;
        end
        dcoc_pkg::PMB_FUNC_LO: begin
          dec_sel = dcoc_pkg::DCOC_SEL_FUNC;
        end
        dcoc_pkg::PMB_RANGE_HI: begin
          dec_sel = dcoc_pkg::DCOC_SEL_RANGE;
          dec_ch = 1'b1;
        end
        dcoc_pkg::PMB_MODE_HI: begin
          dec_sel = dcoc_pkg::DCOC_SEL_MODE;
          dec_ch = 1'b1;
        end
        dcoc_pkg::PMB_FUNC_HI: begin
          dec_sel = dcoc_pkg::DCOC_SEL_FUNC;
          dec_ch = 1'b1;
        end
        default: begin
          dec_hit = 1'b0;
        end
      endcase
      if (pmbus_page_i != dcoc_pkg::PMB_PAGE_CFG) begin
        dec_hit = 1'b0;
      end
    end else begin
      unique case (reg_addr_i)
        dcoc_pkg::OFS_RANGE_LO: begin
          dec_sel = dcoc_pkg::DCOC_SEL_RANGE;
        end
        dcoc_pkg::OFS_MODE_LO: begin
          dec_sel = dcoc_pkg::DCOC_SEL_MODE;
        end
        dcoc_pkg::OFS_FUNC_LO: begin
          dec_sel = dcoc_pkg::DCOC_SEL_FUNC;
        end
        dcoc_pkg::OFS_RANGE_HI: begin
          dec_sel = dcoc_pkg::DCOC_SEL_RANGE;
          dec_ch = 1'b1;
        end
        dcoc_pkg::OFS_MODE_HI: begin
          dec_sel = dcoc_pkg::DCOC_SEL_MODE;
          dec_ch = 1'b1;
        end
        dcoc_pkg::OFS_FUNC_HI: begin
          dec_sel = dcoc_pkg::DCOC_SEL_FUNC;
          dec_ch = 1'b1;
        end
        default: begin
          dec_hit = 1'b0;
        end
      endcase
    end
    // A one-channel part answers nothing for the second bank.
    if (dec_ch && NUM_CH < 2) begin
      dec_hit = 1'b0;
    end
    if (!dec_hit) begin
      dec_sel = dcoc_pkg::DCOC_SEL_NONE;
    end
  end

  assign reg_hit_o = dec_hit;

  // Invalid range and mode codes are stored as written so that a read
  // shows what the host sent; the status outputs flag them instead.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_regs
    logic wr_here;
    logic ch_wr;

    assign wr_here = reg_wr_i && dec_hit && (32'(dec_ch) == c);

    always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
        range_q[c] <= dcoc_pkg::REG_RESET[dcoc_pkg::RANGE_MSB:
                                          dcoc_pkg::RANGE_LSB];
      end else if (wr_here && dec_sel == dcoc_pkg::DCOC_SEL_RANGE) begin
        range_q[c] <= reg_wdata_i[dcoc_pkg::RANGE_MSB:
                                  dcoc_pkg::RANGE_LSB];
      end
    end

    always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
        mode_q[c] <= dcoc_pkg::REG_RESET[dcoc_pkg::MODE_MSB:
                                         dcoc_pkg::MODE_LSB];
      end else if (wr_here && dec_sel == dcoc_pkg::DCOC_SEL_MODE) begin
        mode_q[c] <= reg_wdata_i[dcoc_pkg::MODE_MSB:
                                 dcoc_pkg::MODE_LSB];
      end
    end

    always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
        clr_sel_q[c] <= dcoc_pkg::REG_RESET[dcoc_pkg::CLR_BIT];
        defer_q[c] <= dcoc_pkg::REG_RESET[dcoc_pkg::DEFER_BIT];
        bcast_q[c] <= dcoc_pkg::REG_RESET[dcoc_pkg::BCAST_BIT];
        wave_q[c] <= dcoc_pkg::REG_RESET[dcoc_pkg::WAVE_MSB:
                                         dcoc_pkg::WAVE_LSB];
      end else if (wr_here && dec_sel == dcoc_pkg::DCOC_SEL_FUNC) begin
        clr_sel_q[c] <= reg_wdata_i[dcoc_pkg::CLR_BIT];
        defer_q[c] <= reg_wdata_i[dcoc_pkg::DEFER_BIT];
        bcast_q[c] <= reg_wdata_i[dcoc_pkg::BCAST_BIT];
        wave_q[c] <= reg_wdata_i[dcoc_pkg::WAVE_MSB:dcoc_pkg::WAVE_LSB];
      end
    end

    always_comb begin
      cfg_o[c].clear_level_select = clr_sel_q[c];
      cfg_o[c].deferred_update = defer_q[c];
      cfg_o[c].broadcast_participate = bcast_q[c];
      cfg_o[c].waveform_setup_field = wave_q[c];
      cfg_o[c].current_output_range = range_q[c];
      cfg_o[c].comparator_threshold_mode =
        dcoc_pkg::dcoc_cmp_mode_t'(mode_q[c]);
    end

    // Range family from the upper code bits, span from the lower two.
    always_comb begin
      unique case (range_q[c][3:2])
        dcoc_pkg::RANGE_GRP_SOURCE: begin
          stat_o[c].range_kind = dcoc_pkg::DCOC_RK_SOURCE;
        end
        dcoc_pkg::RANGE_GRP_SINK: begin
          stat_o[c].range_kind = dcoc_pkg::DCOC_RK_SINK;
        end
        dcoc_pkg::RANGE_GRP_BIPOLAR: begin
          stat_o[c].range_kind = dcoc_pkg::DCOC_RK_BIPOLAR;
        end
        default: begin
          stat_o[c].range_kind = dcoc_pkg::DCOC_RK_INVALID;
        end
      endcase
      stat_o[c].range_span = range_q[c][1:0];
      stat_o[c].cmp_mode_invalid =
        mode_q[c] == dcoc_pkg::DCOC_CMP_INVALID;
      stat_o[c].update_pending = chan_pending[c];
      stat_o[c].cmp_out = chan_cmp[c];
    end

    // A broadcast reaches only channels that opted in.
    assign ch_wr = (code_wr_i && code_ch_i[c]) ||
                   (bcast_wr_i && bcast_q[c]);

    // The host keeps the enable low unless the current output is down
    // and voltage mode is on, so no interlock is repeated here.
    dcoc_channel #(
      .CODE_W(CODE_W)
    ) u_channel (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .cfg_i(cfg_o[c]),
      .code_wr_i(ch_wr),
      .code_i(code_i),
      .load_i(load_pulse),
      .clear_i(clear_i),
      .comparator_enable_i(comparator_enable_i[c]),
      .fb_code_i(fb_code_i[c]),
      .margin_hi_i(margin_hi_i[c]),
      .margin_lo_i(margin_lo_i[c]),
      .dac_code_o(dac_code_o[c]),
      .pending_o(chan_pending[c]),
      .cmp_out_o(chan_cmp[c])
    );
  end

  // Read answer one cycle after the request, masked to defined fields.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      if (dec_hit) begin
        unique case (dec_sel)
          dcoc_pkg::DCOC_SEL_RANGE: begin
            reg_rdata_o[dcoc_pkg::RANGE_MSB:dcoc_pkg::RANGE_LSB] <=
              range_q[dec_ch];
          end
          dcoc_pkg::DCOC_SEL_MODE: begin
            reg_rdata_o[dcoc_pkg::MODE_MSB:dcoc_pkg::MODE_LSB] <=
              mode_q[dec_ch];
          end
          dcoc_pkg::DCOC_SEL_FUNC: begin
            reg_rdata_o <= {clr_sel_q[dec_ch], defer_q[dec_ch],
                            bcast_q[dec_ch], wave_q[dec_ch]};
          end
          dcoc_pkg::DCOC_SEL_NONE: begin
            reg_rdata_o <= '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // Idle high, so a strobe held high through reset makes no edge; one held low gives a pulse.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      load_pin_q <= 1'b1;
    end else begin
      load_pin_q <= load_strobe_pin_i;
    end
  end

  assign load_pulse = (load_pin_q && !load_strobe_pin_i) ||
                      trigger_load_i;

endmodule : dcoc_bank

// >>> hdl/dcoc_channel.sv
/*
  One channel: pending and active output codes, clear and load handling,
  and the threshold comparator.
  Assumes the enclosing bank has already turned the load strobe into a
  one-cycle pulse and qualified broadcast writes with the channel's bit.
*/
module dcoc_channel #(
  parameter int CODE_W = 12
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire dcoc_pkg::dcoc_chan_cfg_t cfg_i,
  input wire logic code_wr_i,
  input wire logic [CODE_W-1:0] code_i,
  input wire logic load_i,
  input wire logic clear_i,
  input wire logic comparator_enable_i,
  input wire logic [CODE_W-1:0] fb_code_i,
  input wire logic [CODE_W-1:0] margin_hi_i,
  input wire logic [CODE_W-1:0] margin_lo_i,
  output logic [CODE_W-1:0] dac_code_o,
  output logic pending_o,
  output logic cmp_out_o
);

  localparam logic [CODE_W-1:0] MID_CODE = {1'b1, {(CODE_W-1){1'b0}}};

  logic [CODE_W-1:0] pending_code;
  logic [CODE_W-1:0] clear_code;

  assign clear_code = cfg_i.clear_level_select ? MID_CODE : '0;

  // A clear outranks any write or load in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pending_code <= '0;
      pending_o <= 1'b0;
    end else if (clear_i) begin
      pending_code <= clear_code;
      pending_o <= 1'b0;
    end else if (code_wr_i) begin
      pending_code <= code_i;
      pending_o <= cfg_i.deferred_update;
    end else if (load_i) begin
      pending_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      dac_code_o <= '0;
    end else if (clear_i) begin
      dac_code_o <= clear_code;
    end else if (code_wr_i && !cfg_i.deferred_update) begin
      dac_code_o <= code_i;
    end else if (load_i && pending_o) begin
      dac_code_o <= pending_code;
    end
  end

  // Hysteresis holds its state between the two margins.
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !comparator_enable_i) begin
      cmp_out_o <= 1'b0;
    end else begin
      unique case (cfg_i.comparator_threshold_mode)
        dcoc_pkg::DCOC_CMP_PLAIN: begin
          cmp_out_o <= fb_code_i > dac_code_o;
        end
        dcoc_pkg::DCOC_CMP_HYST: begin
          if (fb_code_i >= margin_hi_i) begin
            cmp_out_o <= 1'b1;
          end else if (fb_code_i <= margin_lo_i) begin
            cmp_out_o <= 1'b0;
          end
        end
        dcoc_pkg::DCOC_CMP_WINDOW: begin
          cmp_out_o <= fb_code_i >= margin_lo_i &&
                       fb_code_i <= margin_hi_i;
        end
        dcoc_pkg::DCOC_CMP_INVALID: begin
          cmp_out_o <= 1'b0;
        end
      endcase
    end
  end

endmodule : dcoc_channel

// >>> hdl/dcoc_pkg.sv
/*
  Shared constants and types for the DAC channel output configuration bank.
  Assumes a host-side serial front end that delivers decoded register
  accesses and a PMBus page number to the bank.
*/
package dcoc_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int MAX_CH = 2;

  // Direct register offsets, one bank per channel.
  localparam logic [7:0] OFS_RANGE_LO = 8'h04;
  localparam logic [7:0] OFS_MODE_LO = 8'h05;
  localparam logic [7:0] OFS_FUNC_LO = 8'h06;
  localparam logic [7:0] OFS_RANGE_HI = 8'h16;
  localparam logic [7:0] OFS_MODE_HI = 8'h17;
  localparam logic [7:0] OFS_FUNC_HI = 8'h18;

  // PMBus page and register addresses of the same registers.
  localparam logic [7:0] PMB_PAGE_CFG = 8'hff;
  localparam logic [7:0] PMB_RANGE_LO = 8'hd2;
  localparam logic [7:0] PMB_MODE_LO = 8'hd3;
  localparam logic [7:0] PMB_FUNC_LO = 8'hd4;
  localparam logic [7:0] PMB_RANGE_HI = 8'hde;
  localparam logic [7:0] PMB_MODE_HI = 8'hdf;
  localparam logic [7:0] PMB_FUNC_HI = 8'he0;

  localparam logic [15:0] REG_RESET = 16'h0000;

  // Field positions.
  localparam int RANGE_LSB = 9;
  localparam int RANGE_MSB = 12;
  localparam int MODE_LSB = 10;
  localparam int MODE_MSB = 11;
  localparam int CLR_BIT = 15;
  localparam int DEFER_BIT = 14;
  localparam int BCAST_BIT = 13;
  localparam int WAVE_MSB = 12;
  localparam int WAVE_LSB = 0;

  // Upper two bits of the range code pick the range family.
  localparam logic [1:0] RANGE_GRP_SOURCE = 2'h0;
  localparam logic [1:0] RANGE_GRP_SINK = 2'h1;
  localparam logic [1:0] RANGE_GRP_BIPOLAR = 2'h2;

  typedef enum logic [1:0] {
    DCOC_CMP_PLAIN = 2'h0,
    DCOC_CMP_HYST = 2'h1,
    DCOC_CMP_WINDOW = 2'h2,
    DCOC_CMP_INVALID = 2'h3
  } dcoc_cmp_mode_t;

  typedef enum logic [1:0] {
    DCOC_RK_SOURCE,
    DCOC_RK_SINK,
    DCOC_RK_BIPOLAR,
    DCOC_RK_INVALID
  } dcoc_range_kind_t;

  typedef enum logic [1:0] {
    DCOC_SEL_NONE,
    DCOC_SEL_RANGE,
    DCOC_SEL_MODE,
    DCOC_SEL_FUNC
  } dcoc_reg_sel_t;

  typedef struct packed {
    logic clear_level_select;
    logic deferred_update;
    logic broadcast_participate;
    logic [12:0] waveform_setup_field;
    logic [3:0] current_output_range;
    dcoc_cmp_mode_t comparator_threshold_mode;
  } dcoc_chan_cfg_t;

  typedef struct packed {
    dcoc_range_kind_t range_kind;
    logic [1:0] range_span;
    logic cmp_mode_invalid;
    logic update_pending;
    logic cmp_out;
  } dcoc_chan_stat_t;

endpackage : dcoc_pkg

// >>> tb/dcoc_bank_sva.sv
/*
  Checker for access timing, field storage and output updates.
  Assumes it is bound into the bank and shares its clock and reset.
*/
module dcoc_bank_sva #(
  parameter int NUM_CH = 2,
  parameter int CODE_W = 12
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pmbus_mode_i,
  input wire logic [7:0] pmbus_page_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic reg_hit_o,
  input wire logic code_wr_i,
  input wire logic [NUM_CH-1:0] code_ch_i,
  input wire logic [CODE_W-1:0] code_i,
  input wire logic clear_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] dac_code_o,
  input wire dcoc_pkg::dcoc_chan_cfg_t [NUM_CH-1:0] cfg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic dw;
  logic [15:0] wd_q;
  logic [CODE_W-1:0] cq;
  assign dw = reg_wr_i && !pmbus_mode_i;
  always_ff @(posedge clk_i) begin
    wd_q <= reg_wdata_i;
    cq <= code_i;
  end
  property p_rvalid;
    reg_rvalid_o == $past(reg_rd_i);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid late");
  property p_reset;
    $rose(nrst_i) |-> cfg_o == '0 && dac_code_o == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value");
  property p_wr_range;
    dw && reg_addr_i == 8'h04 |=> cfg_o[0].current_output_range == wd_q[12:9];
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("range");
  property p_wr_mode;
    dw && reg_addr_i == 8'h05
      |=> cfg_o[0].comparator_threshold_mode == wd_q[11:10];
  endproperty
  a_wr_mode: assert property (p_wr_mode) else $error("mode");
  property p_wr_func;
    dw && reg_addr_i == 8'h06 |=> {cfg_o[0].clear_level_select,
      cfg_o[0].deferred_update, cfg_o[0].broadcast_participate} == wd_q[15:13];
  endproperty
  a_wr_func: assert property (p_wr_func) else $error("function");
  property p_page;
    pmbus_mode_i && pmbus_page_i != 8'hff |-> !reg_hit_o;
  endproperty
  a_page: assert property (p_page) else $error("page decode");
  property p_rd_mask;
    reg_rd_i && !pmbus_mode_i && reg_addr_i == 8'h05
      |=> reg_rvalid_o && (reg_rdata_o & 16'hf3ff) == 16'h0000;
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("spare bits");
  property p_imm;
    code_wr_i && code_ch_i[0] && !cfg_o[0].deferred_update && !clear_i
      |=> dac_code_o[0] == cq;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate update");
  property p_clear;
    clear_i && !reg_wr_i
      |=> dac_code_o[0] == {cfg_o[0].clear_level_select, {(CODE_W-1){1'b0}}};
  endproperty
  a_clear: assert property (p_clear) else $error("clear level");
endmodule : dcoc_bank_sva

bind dcoc_bank dcoc_bank_sva #(.NUM_CH(NUM_CH), .CODE_W(CODE_W))
  i_dcoc_bank_sva (.clk_i, .nrst_i, .pmbus_mode_i, .pmbus_page_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
  .reg_hit_o, .code_wr_i, .code_ch_i, .code_i, .clear_i, .dac_code_o, .cfg_o);

// >>> tb/dcoc_bank_tb.sv
/*
  Self-checking bench for the configuration bank, driven by a host model.
  Assumes the package, design, host model and checker compile first.
*/
module dcoc_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic nrst_i;
  logic pm, wr, rd, hit, rv, cw, bc, pin, trig, clr;
  logic [7:0] page, addr;
  logic [15:0] wd, rdat;
  logic [1:0] ch, cen;
  logic [11:0] code;
  logic [1:0][11:0] fb, mhi, mlo, dac;
  dcoc_pkg::dcoc_chan_cfg_t [1:0] cfg;
  dcoc_pkg::dcoc_chan_stat_t [1:0] stat;
  int check_count = 0;
  int miscompares = 0;
  logic [7:0] pma[6] = '{8'hd2, 8'hd3, 8'hd4, 8'hde, 8'hdf, 8'he0};
  logic [7:0] ofs[6] = '{8'h04, 8'h05, 8'h06, 8'h16, 8'h17, 8'h18};
  logic [15:0] ex[6] = '{16'h1600, 16'h0400, 16'hf7ff,
                         16'h1600, 16'h0400, 16'hf7ff};
  logic [1:0] tm[7] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  logic [11:0] tf[7] = '{12'h900, 12'h700, 12'h400, 12'h700,
                         12'h600, 12'h400, 12'h200};
  logic te[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  dcoc_host i_dcoc_host (.clk_i, .rdata_i(rdat), .rvalid_i(rv), .pm_o(pm),
    .page_o(page), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
  dcoc_bank #(.NUM_CH(2), .CODE_W(12)) i_dcoc_bank (.clk_i, .nrst_i,
    .pmbus_mode_i(pm), .pmbus_page_i(page), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .reg_hit_o(hit), .code_wr_i(cw), .code_ch_i(ch),
    .bcast_wr_i(bc), .code_i(code), .load_strobe_pin_i(pin),
    .trigger_load_i(trig), .clear_i(clr), .comparator_enable_i(cen),
    .fb_code_i(fb), .margin_hi_i(mhi), .margin_lo_i(mlo), .dac_code_o(dac),
    .cfg_o(cfg), .stat_o(stat));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_dcoc_host.rd(1'b0, a, d);
    chk(d, exp);
  endtask : rchk
  task automatic wrd(input logic [7:0] a, input logic [15:0] d);
    i_dcoc_host.wr(1'b0, 8'hff, a, d);
  endtask : wrd
  task automatic cwr(input logic [1:0] c, input logic b,
                     input logic [11:0] k);
    @(negedge clk_i);
    cw = |c;
    ch = c;
    bc = b;
    code = k;
    @(negedge clk_i);
    cw = 1'b0;
    bc = 1'b0;
  endtask : cwr
  // Returns one edge after the strobe, so checks see the exact latency.
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = ~s;
    @(negedge clk_i);
    s = ~s;
  endtask : pulse
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    {nrst_i, cw, ch, bc, code, trig, clr, cen, fb} = '0;
    pin = 1'b1;
    mhi = {12'h000, 12'h600};
    mlo = {12'h000, 12'h200};
    repeat (20) @(negedge clk_i);
    nrst_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rchk(ofs[i], 16'h0000);
    end
    for (int c = 0; c < 16; c++) begin
      wrd(8'h04, {3'h7, c[3:0], 9'h1ff});
      rchk(8'h04, {3'h0, c[3:0], 9'h000});
      chk(16'({stat[0].range_kind, stat[0].range_span}), 16'(c[3:0]));
    end
    for (int i = 0; i < 6; i++) begin
      i_dcoc_host.wr(1'b1, 8'hff, pma[i], 16'hf7ff);
      rchk(ofs[i], ex[i]);
    end
    i_dcoc_host.wr(1'b1, 8'h00, 8'hd2, 16'h0000);
    chk(16'(hit), 16'h0000);
    rchk(8'h04, 16'h1600);
    rchk(8'h07, 16'h0000);
    chk(16'(hit), 16'h0000);
    wrd(8'h06, 16'h0000);
    wrd(8'h18, 16'h2000);
    cwr(2'b01, 1'b0, 12'h123);
    chk(16'(dac[0]), 16'h0123);
    wrd(8'h06, 16'h4000);
    cwr(2'b01, 1'b0, 12'h456);
    chk(16'(stat[0].update_pending), 16'h0001);
    chk(16'(dac[0]), 16'h0123);
    pulse(pin);
    chk(16'(dac[0]), 16'h0456);
    cwr(2'b01, 1'b0, 12'h789);
    pulse(trig);
    chk(16'(dac[0]), 16'h0789);
    cwr(2'b00, 1'b1, 12'h0aa);
    chk(16'(dac[1]), 16'h00aa);
    chk(16'(dac[0]), 16'h0789);
    wrd(8'h06, 16'h8000);
    pulse(clr);
    chk(16'(dac[0]), 16'h0800);
    chk(16'(dac[1]), 16'h0000);
    // Enabled only with the channel left in voltage output mode.
    cen = 2'b01;
    for (int i = 0; i < 7; i++) begin
      wrd(8'h05, {4'h0, tm[i], 10'h000});
      fb[0] = tf[i];
      repeat (2) @(negedge clk_i);
      chk(16'(stat[0].cmp_out), 16'(te[i]));
    end
    fb[0] = 12'h900;
    wrd(8'h05, 16'h0c00);
    repeat (2) @(negedge clk_i);
    chk(16'(stat[0].cmp_mode_invalid), 16'h0001);
    chk(16'(stat[0].cmp_out), 16'h0000);
    close_out();
  end
endmodule : dcoc_bank_tb

// >>> tb/dcoc_host.sv
/*
  Host model that issues register accesses on the bank's access port.
  Assumes the bench clock; requests start and end on its falling edge.
*/
module dcoc_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output logic pm_o,
  output logic [7:0] page_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {pm_o, wr_o, rd_o, addr_o, wdata_o} = '0;
    page_o = 8'hff;
  end
  // Invalid range and mode codes are sent only to see them flagged.
  task automatic wr(input logic pm, input logic [7:0] pg,
                    input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    pm_o = pm;
    page_o = pg;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    // Stale data is inverted so a late sample cannot pass by luck.
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic pm, input logic [7:0] a,
                    output logic [15:0] d);
    @(negedge clk_i);
    pm_o = pm;
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    d = rvalid_i ? rdata_i : 16'hxxxx;
  endtask : rd
endmodule : dcoc_host
